// File: verilog/irs_slave.sv
// Contract
// - Command byte acknowledged; its low five bits load the pointer.
// - Repeated start with read bit; device acks, sends pointed byte.
// - Master ends a read with a stop condition.
// - Pointer advances by one after each returned data byte.
// - Master acknowledge makes the device send the next register.
// - Pointer after 1Dh wraps to the status register 00h.
// - Control registers hold zero after power-on: single-ended voltage.
// - No diode currents or terminations are enabled at power-up.
// - Single-shot and repeated measurement modes selectable by control.
// - Temperature scale Celsius or Kelvin set by a control bit.
// - Channel enables pick selected or all measurements.
// - New result data sets that result's fresh flag.
// - Reading a result byte clears its fresh flag in both places.
// - Busy is high while a single-shot conversion runs.
// - Busy stays high in repeated mode after the first trigger.
// - Slave address is one of eight, set by three select pins.
// - Shared sync address accepted for writes only.
// - Result updates are held off during a serial read.
// - Writes acknowledged, stored only at 01h and 06h-09h; next byte to the next register.
`timescale 1ns/100ps
`default_nettype none
module irs_slave
    import irs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rstn_in,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Address select pins
    input wire logic addr_select_pin_0_in,
    input wire logic addr_select_pin_1_in,
    input wire logic addr_select_pin_2_in,
    // Conversion sequencer
    input wire logic conv_valid_in,
    input wire logic [3:0] conv_index_in,
    input wire logic [7:0] conv_msb_in,
    input wire logic [7:0] conv_lsb_in,
    input wire logic conv_done_in,
    output logic conv_hold_out,
    output logic trigger_out,
    // Configuration and status
    output logic busy_out,
    output logic repeat_mode_out,
    output logic kelvin_out,
    output logic [4:0] chan_enable_out,
    output logic [3:0] diode_drive_out
);
    irs_state_e state;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [4:0] ptr;
    logic rw;
    logic ack_seen;
    logic scl_d;
    logic sda_d;
    logic [4:0] pins;
    logic [9:0] fresh;
    logic [7:0] regs [0:NUM_REGS-1];

    function automatic logic [4:0] next_ptr(input logic [4:0] p);
        next_ptr = (p == REG_LAST) ? REG_STATUS_LO : 5'(p + 5'h01);
    endfunction

    function automatic logic is_result(input logic [4:0] p);
        is_result = (p >= REG_RESULT_FIRST) && (p <= REG_LAST);
    endfunction

    function automatic logic [3:0] pair_of(input logic [4:0] p);
        logic [4:0] d;
        d = 5'(p - REG_RESULT_FIRST);
        pair_of = d[4:1];
    endfunction

    function automatic logic is_writable(input logic [4:0] p);
        is_writable = (p == REG_STATUS_HI) ||
            ((p >= REG_CTRL_A) && (p <= REG_PWM_HI));
    endfunction

    irs_pin_sync u_sync (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .pins_in({addr_select_pin_2_in, addr_select_pin_1_in,
            addr_select_pin_0_in, sda_in, scl_in}),
        .pins_out(pins)
    );

    wire scl_s = pins[0];
    wire sda_s = pins[1];
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_det = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
    wire byte_done = scl_fall && (cnt == BITS_PER_BYTE);
    wire [6:0] own_addr = {ADDR_BASE[6:3], pins[4:2]};
    wire addr_hit = (sh[7:1] == own_addr) ||
        ((sh[7:1] == ADDR_SYNC) && !sh[0]);
    wire [3:0] res_idx = pair_of(ptr);
    wire [7:0] hi_status = {regs[REG_STATUS_HI][7:3], busy_out,
        fresh[PAIR_TINT], fresh[PAIR_VCC]};
    wire [7:0] rd_byte = (ptr == REG_STATUS_LO) ? fresh[7:0] :
        (ptr == REG_STATUS_HI) ? hi_status :
        (is_result(ptr) && !ptr[0]) ?
            {fresh[res_idx], regs[ptr][6:0]} :
        (ptr <= REG_LAST) ? regs[ptr] : REG_RESET;
    wire tx_load = scl_fall && (((state == ST_ADDR_ACK) && rw) ||
        ((state == ST_RACK) && ack_seen));
    wire wr_strobe = (state == ST_WDATA) && byte_done;
    // Sequencer writes ignored while a read holds it off
    wire conv_take = conv_valid_in && !conv_hold_out &&
        (conv_index_in < NUM_RESULTS);
    wire [4:0] res_addr = 5'(REG_RESULT_FIRST + {conv_index_in, 1'b0});
    wire [9:0] clr_mask = (tx_load && is_result(ptr)) ?
        10'(10'h001 << res_idx) : 10'h000;
    wire [9:0] set_mask = conv_take ? 10'(10'h001 << conv_index_in) : 10'h000;
    // Set wins over a clear in the same cycle
    wire [9:0] next_fresh = (fresh & ~clr_mask) | set_mask;
    wire trig_now = wr_strobe && (ptr == REG_STATUS_HI);

    assign repeat_mode_out = regs[REG_CTRL_C][BIT_REPEAT];
    assign kelvin_out = regs[REG_CTRL_C][BIT_KELVIN];
    assign chan_enable_out = regs[REG_STATUS_HI][7:CH_EN_LSB];
    assign diode_drive_out = {regs[REG_CTRL_B][BIT_DIODE_HI],
        regs[REG_CTRL_B][BIT_DIODE_LO], regs[REG_CTRL_A][BIT_DIODE_HI],
        regs[REG_CTRL_A][BIT_DIODE_LO]};

    always_ff @(posedge core_clk_in)
    begin
        if (!rstn_in)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            sda_out <= 1'b0;
        end
        else
        begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            sda_out <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!rstn_in)
        begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            sh <= 8'h00;
            ptr <= REG_STATUS_LO;
            rw <= 1'b0;
            ack_seen <= 1'b0;
            sda_oe_out <= 1'b0;
            conv_hold_out <= 1'b0;
        end
        // Start or repeated start begins address phase
        else if (start_det)
        begin
            state <= ST_ADDR;
            cnt <= 4'h0;
            sda_oe_out <= 1'b0;
            conv_hold_out <= 1'b0;
        end
        else if (stop_det)
        begin
            state <= ST_IDLE;
            sda_oe_out <= 1'b0;
            conv_hold_out <= 1'b0;
        end
        else
        begin
            case (state)
                ST_ADDR, ST_CMD, ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        sh <= {sh[6:0], sda_s};
                        cnt <= 4'(cnt + 4'h1);
                    end
                    else if (byte_done)
                    begin
                        sda_oe_out <= 1'b1;
                        if (state == ST_ADDR)
                        begin
                            rw <= sh[0];
                            // Foreign reads must not stall the sequencer
                            conv_hold_out <= sh[0] & addr_hit;
                            state <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
                            sda_oe_out <= addr_hit;
                        end
                        else if (state == ST_CMD)
                        begin
                            ptr <= sh[4:0];
                            state <= ST_CMD_ACK;
                        end
                        else
                        begin
                            ptr <= next_ptr(ptr);
                            state <= ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        cnt <= 4'h0;
                        sh <= rd_byte;
                        sda_oe_out <= rw & ~rd_byte[7];
                        state <= rw ? ST_RDATA : ST_CMD;
                    end
                end
                ST_CMD_ACK, ST_WDATA_ACK:
                begin
                    if (scl_fall)
                    begin
                        cnt <= 4'h0;
                        sda_oe_out <= 1'b0;
                        state <= ST_WDATA;
                    end
                end
                ST_RDATA:
                begin
                    if (scl_rise)
                        cnt <= 4'(cnt + 4'h1);
                    else if (scl_fall && (cnt == BITS_PER_BYTE))
                    begin
                        ptr <= next_ptr(ptr);
                        sda_oe_out <= 1'b0;
                        state <= ST_RACK;
                    end
                    else if (scl_fall)
                    begin
                        sh <= {sh[6:0], 1'b0};
                        sda_oe_out <= ~sh[6];
                    end
                end
                ST_RACK:
                begin
                    if (scl_rise)
                        ack_seen <= ~sda_s;
                    else if (scl_fall && ack_seen)
                    begin
                        cnt <= 4'h0;
                        sh <= rd_byte;
                        sda_oe_out <= ~rd_byte[7];
                        state <= ST_RDATA;
                    end
                    else if (scl_fall)
                    begin
                        state <= ST_IDLE;
                        conv_hold_out <= 1'b0;
                    end
                end
                default:
                    cnt <= 4'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!rstn_in)
        begin
            for (int i = 0; i < NUM_REGS; i++)
                regs[i] <= REG_RESET;
            fresh <= 10'h000;
            busy_out <= 1'b0;
            trigger_out <= 1'b0;
        end
        else
        begin
            fresh <= next_fresh;
            trigger_out <= trig_now;
            if (wr_strobe && is_writable(ptr))
                regs[ptr] <= (ptr == REG_STATUS_HI) ? {sh[7:3], 3'h0} : sh;
            if (conv_take)
            begin
                regs[res_addr] <= {1'b0, conv_msb_in[6:0]};
                regs[5'(res_addr + 5'h01)] <= conv_lsb_in;
            end
            // Busy from trigger to end of single shot
            if (trig_now)
                busy_out <= 1'b1;
            else if (conv_done_in && !repeat_mode_out)
                busy_out <= 1'b0;
        end
    end

    ptr_load_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        (state == ST_CMD && byte_done && !start_det && !stop_det)
        |=> ptr == $past(sh[4:0]))
        else $error("pointer not loaded from command");

    ptr_wrap_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        (state == ST_RDATA && byte_done && ptr == REG_LAST &&
        !start_det && !stop_det) |=> ptr == REG_STATUS_LO)
        else $error("pointer did not wrap");

    ptr_step_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        (state == ST_RDATA && byte_done && ptr < REG_LAST &&
        !start_det && !stop_det) |=> ptr == 5'($past(ptr) + 5'h01))
        else $error("pointer did not advance");

    fresh_set_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        conv_take |=> fresh[$past(conv_index_in)])
        else $error("fresh flag not set");

    fresh_clr_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        (tx_load && is_result(ptr) && !conv_valid_in)
        |=> !fresh[$past(res_idx)])
        else $error("fresh flag not cleared");

    hold_off_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        conv_hold_out |=> (fresh & ~$past(fresh)) == 10'h000)
        else $error("result updated during read");

    busy_rise_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        trig_now |=> busy_out && trigger_out)
        else $error("busy not raised on trigger");

    busy_repeat_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        busy_out && repeat_mode_out |=> busy_out)
        else $error("busy dropped in repeated mode");

    reset_idle_a: assert property (@(posedge core_clk_in)
        !rstn_in |=> diode_drive_out == 4'h0 && !repeat_mode_out &&
        !kelvin_out && chan_enable_out == 5'h00)
        else $error("control not zero after reset");

    nack_release_a: assert property (@(posedge core_clk_in)
        disable iff (!rstn_in)
        (state == ST_RACK && scl_fall && !ack_seen && !start_det &&
        !stop_det) |=> state == ST_IDLE && !sda_oe_out [*2])
        else $error("device kept driving after not-acknowledge");
endmodule
`default_nettype wire

// File: verilog/irs_pkg.sv
`default_nettype none
package irs_pkg;
    // Slave address: upper four bits fixed, low three from the select pins
    localparam logic [6:0] ADDR_BASE = 7'h48;
    localparam logic [6:0] ADDR_SYNC = 7'h77;
    // Register pointer values
    localparam logic [4:0] REG_STATUS_LO = 5'h00;
    localparam logic [4:0] REG_STATUS_HI = 5'h01;
    localparam logic [4:0] REG_CTRL_A = 5'h06;
    localparam logic [4:0] REG_CTRL_B = 5'h07;
    localparam logic [4:0] REG_CTRL_C = 5'h08;
    localparam logic [4:0] REG_PWM_HI = 5'h09;
    localparam logic [4:0] REG_RESULT_FIRST = 5'h0a;
    localparam logic [4:0] REG_LAST = 5'h1d;
    localparam int NUM_REGS = 30;
    localparam logic [3:0] NUM_RESULTS = 4'ha;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Field positions
    localparam int BIT_VCC_FRESH = 0;
    localparam int BIT_TINT_FRESH = 1;
    localparam int BIT_BUSY = 2;
    localparam int CH_EN_LSB = 3;
    localparam int BIT_FRESH_MSB = 7;
    localparam int BIT_KELVIN = 2;
    localparam int BIT_REPEAT = 4;
    localparam int BIT_DIODE_LO = 1;
    localparam int BIT_DIODE_HI = 5;
    localparam int PAIR_TINT = 8;
    localparam int PAIR_VCC = 9;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    typedef enum {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_CMD,
        ST_CMD_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RACK
    } irs_state_e;
endpackage
`default_nettype wire

// File: verilog/irs_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module irs_pin_sync
    import irs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rstn_in,
    // Raw pins and their synchronised copies
    input wire logic [4:0] pins_in,
    output logic [4:0] pins_out
);
    logic [4:0] stage1;

    // Idle bus reads high, so reset to ones avoids a false start
    always_ff @(posedge core_clk_in)
    begin
        if (!rstn_in)
        begin
            stage1 <= 5'h1f;
            pins_out <= 5'h1f;
        end
        else
        begin
            stage1 <= pins_in;
            pins_out <= stage1;
        end
    end
endmodule
`default_nettype wire

// File: tb/irs_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module irs_master_model
(
    // Clock
    input wire logic core_clk_in,
    // Bus lines
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    // Phases well above the four-cycle minimum of the slave
    localparam int HALF = 8;
    initial
    begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask
    task automatic start_c();
        sda_low_out <= 1'b0;
        wait_clk(HALF);
        scl_out <= 1'b1;
        wait_clk(HALF);
        sda_low_out <= 1'b1;
        wait_clk(HALF);
        scl_out <= 1'b0;
        wait_clk(HALF);
    endtask
    task automatic stop_c();
        sda_low_out <= 1'b1;
        wait_clk(HALF);
        scl_out <= 1'b1;
        wait_clk(HALF);
        sda_low_out <= 1'b0;
        wait_clk(HALF);
    endtask
    // Data held two cycles past the fall to keep hold time
    task automatic bit_c(input logic b, output logic r);
        sda_low_out <= ~b;
        wait_clk(HALF);
        scl_out <= 1'b1;
        wait_clk(HALF);
        r = sda_in;
        scl_out <= 1'b0;
        wait_clk(2);
    endtask
    // Ninth bit carries ack or final not-acknowledge
    task automatic xfer(input logic [7:0] d, input logic last,
                        output logic [7:0] q, output logic nine);
        for (int i = 7; i >= 0; i--)
            bit_c(d[i], q[i]);
        bit_c(last, nine);
    endtask
endmodule
`default_nettype wire

// File: tb/irs_slave_tb.sv
`timescale 1ns/100ps
`default_nettype none
module irs_slave_tb
    import irs_pkg::*;
;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic scl, m_low, sda_out, sda_oe, conv_hold, trigger, busy;
    logic repeat_mode, kelvin, conv_valid, conv_done;
    logic [2:0] sel;
    logic [3:0] conv_index, diode;
    logic [4:0] chan_en;
    logic [6:0] own;
    logic [7:0] conv_msb, conv_lsb, d0, d1;
    logic [7:0] rbuf [4];
    logic [7:0] msb [10];
    logic [7:0] lsb [10];
    logic ack_a, ack_c, ack_r, ack_d;
    wire sda_wire;
    int errors = 0;
    int num_checks = 0;
    int trig_cnt = 0;
    int n, idx;
    // Open drain with pull-up: low if any party pulls
    assign sda_wire = ~(m_low | (sda_oe & ~sda_out));
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk)
        if (trigger === 1'b1)
            trig_cnt <= trig_cnt + 1;
    irs_master_model i_irs_master_model (.core_clk_in(core_clk),
        .sda_in(sda_wire), .scl_out(scl), .sda_low_out(m_low));
    irs_slave i_irs_slave (.core_clk_in(core_clk), .rstn_in(rstn),
        .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe_out(sda_oe), .addr_select_pin_0_in(sel[0]),
        .addr_select_pin_1_in(sel[1]), .addr_select_pin_2_in(sel[2]),
        .conv_valid_in(conv_valid), .conv_index_in(conv_index),
        .conv_msb_in(conv_msb), .conv_lsb_in(conv_lsb),
        .conv_done_in(conv_done), .conv_hold_out(conv_hold),
        .trigger_out(trigger), .busy_out(busy),
        .repeat_mode_out(repeat_mode), .kelvin_out(kelvin),
        .chan_enable_out(chan_en), .diode_drive_out(diode));
    function automatic logic [4:0] result_ptr(input int i);
        return REG_RESULT_FIRST + 5'(2 * i);
    endfunction
    function automatic logic [7:0] diode_exp(input logic [7:0] a, b);
        return {4'h0, b[BIT_DIODE_HI], b[BIT_DIODE_LO],
                a[BIT_DIODE_HI], a[BIT_DIODE_LO]};
    endfunction
    task automatic compare(input string what, input logic [7:0] exp,
                           input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic read_regs(input logic [6:0] a, input logic [4:0] p,
                             input int cnt);
        logic [7:0] q;
        logic k;
        i_irs_master_model.start_c();
        i_irs_master_model.xfer({a, 1'b0}, 1'b1, q, ack_a);
        i_irs_master_model.xfer({3'h0, p}, 1'b1, q, ack_c);
        i_irs_master_model.start_c();
        i_irs_master_model.xfer({a, 1'b1}, 1'b1, q, ack_r);
        for (int i = 0; i < cnt; i++)
            i_irs_master_model.xfer(8'hff, i == cnt - 1, rbuf[i], k);
        i_irs_master_model.stop_c();
    endtask
    task automatic write_regs(input logic [6:0] a, input logic [4:0] p,
                              input logic [7:0] x0, x1, input int cnt);
        logic [7:0] q;
        i_irs_master_model.start_c();
        i_irs_master_model.xfer({a, 1'b0}, 1'b1, q, ack_a);
        i_irs_master_model.xfer({3'h0, p}, 1'b1, q, ack_c);
        i_irs_master_model.xfer(x0, 1'b1, q, ack_d);
        if (cnt > 1)
            i_irs_master_model.xfer(x1, 1'b1, q, ack_d);
        i_irs_master_model.stop_c();
    endtask
    task automatic post(input int i, input logic [7:0] m, l);
        conv_index <= 4'(i);
        conv_msb <= m;
        conv_lsb <= l;
        conv_valid <= 1'b1;
        @(posedge core_clk);
        conv_valid <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic pulse_done();
        conv_done <= 1'b1;
        @(posedge core_clk);
        conv_done <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    initial
    begin
        repeat (90000) @(posedge core_clk);
        errors++;
        conclude();
    end
    initial
    begin
        {sel, conv_valid, conv_done, conv_index, conv_msb, conv_lsb} = '0;
        void'($urandom(10));
        @(posedge core_clk);
        sel <= 3'($urandom);
        @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
        own = {ADDR_BASE[6:3], sel};
        compare("cfg", 8'h00,
            {diode, repeat_mode, kelvin, busy, conv_hold});
        compare("chan_en", 8'h00, {3'h0, chan_en});
        read_regs(own, REG_CTRL_A, 4);
        compare("acks", 8'h00,
            {5'h0, ack_a, ack_c, ack_r});
        for (int i = 0; i < 4; i++)
            compare("ctrl_rst", REG_RESET, rbuf[i]);
        $display("test reset done");
        write_regs(own ^ 7'h01, REG_CTRL_C, 8'h14, 8'h00, 1);
        compare("foreign", 8'h01, {7'h0, ack_a});
        compare("foreign_cfg", 8'h00,
            {6'h0, repeat_mode, kelvin});
        for (int k = 0; k < 4; k++)
        begin
            d0 = 8'($urandom);
            d1 = 8'($urandom);
            write_regs(own, REG_CTRL_A, d0, d1, 2);
            compare("wr_ack", 8'h00, {7'h0, ack_d});
            compare("diode", diode_exp(d0, d1),
                {4'h0, diode});
            read_regs(own, REG_CTRL_A, 2);
            compare("ctrl_a", d0, rbuf[0]);
            compare("ctrl_b", d1, rbuf[1]);
            d0 = 8'($urandom) & 8'h14;
            write_regs(own, REG_CTRL_C, d0, 8'h00, 1);
            compare("mode", {6'h0, d0[4], d0[2]},
                {6'h0, repeat_mode, kelvin});
        end
        // Second byte lands on a result register, which must stay untouched
        d0 = 8'($urandom);
        d1 = 8'($urandom) | 8'h01;
        write_regs(own, REG_PWM_HI, d0, d1, 2);
        read_regs(own, REG_PWM_HI, 2);
        compare("pwm_hi", d0, rbuf[0]);
        compare("read_only", 8'h00, rbuf[1]);
        $display("test config done");
        for (int k = 0; k < 2; k++)
        begin
            write_regs(own, REG_CTRL_C, {3'h0, k[0], 4'h0}, 8'h00, 1);
            d0 = {5'($urandom), 3'h0};
            n = trig_cnt;
            write_regs(own, REG_STATUS_HI, d0, 8'h00, 1);
            compare("trigger", 8'(n + 1), 8'(trig_cnt));
            compare("chan_en", {3'h0, d0[7:3]}, {3'h0, chan_en});
            compare("busy", 8'h01, {7'h0, busy});
            pulse_done();
            compare("busy_end", {7'h0, k[0]},
                {7'h0, busy});
        end
        write_regs(own, REG_CTRL_C, 8'h00, 8'h00, 1);
        pulse_done();
        compare("busy_off", 8'h00, {7'h0, busy});
        $display("test busy done");
        for (int i = 0; i < 10; i++)
        begin
            msb[i] = 8'($urandom);
            lsb[i] = 8'($urandom);
            post(i, msb[i], lsb[i]);
        end
        read_regs(own, REG_STATUS_LO, 2);
        compare("status_lo", 8'hff, rbuf[0]);
        compare("status_hi", 8'h03, rbuf[1] & 8'h03);
        idx = $urandom % 8;
        read_regs(own, result_ptr(idx), 2);
        compare("res_msb", {1'b1, msb[idx][6:0]},
            rbuf[0]);
        compare("res_lsb", lsb[idx], rbuf[1]);
        d1 = 8'hff & ~(8'h01 << idx);
        read_regs(own, REG_STATUS_LO, 1);
        compare("status_clr", d1, rbuf[0]);
        read_regs(own, result_ptr(idx), 1);
        compare("fresh_bit", 8'h00, {7'h0, rbuf[0][7]});
        read_regs(own, REG_LAST, 2);
        compare("vcc_lsb", lsb[9], rbuf[0]);
        compare("wrap", d1, rbuf[1]);
        $display("test fresh done");
        fork
            read_regs(own, REG_STATUS_LO, 3);
            begin
                n = 0;
                while (conv_hold !== 1'b1 && n < 3000)
                begin
                    @(posedge core_clk);
                    n++;
                end
                compare("hold", 8'h01, {7'h0, conv_hold});
                post(idx, 8'h00, 8'h00);
            end
        join
        compare("released", 8'h00,
            {6'h0, conv_hold, sda_oe});
        read_regs(own, REG_STATUS_LO, 1);
        compare("held_off", d1, rbuf[0]);
        $display("test hold done");
        write_regs(ADDR_SYNC, REG_CTRL_C, 8'h04, 8'h00, 1);
        compare("sync_ack", 8'h00, {7'h0, ack_a});
        compare("sync_cfg", 8'h01, {7'h0, kelvin});
        read_regs(ADDR_SYNC, REG_CTRL_C, 1);
        compare("sync_read", 8'h01, {7'h0, ack_r});
        $display("test sync done");
        conclude();
    end
endmodule
`default_nettype wire
